// *** status_flags_defines.svh ***
`ifndef STATUS_FLAGS_DEFINES_SVH
`define STATUS_FLAGS_DEFINES_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define ERROR_FLAGS_INDEX 8'h06
`define GENERAL_STATUS_INDEX 8'h07
`define FLAGS_CONTROL_INDEX 8'h10

// ---------------------------------------------------------------
// error_flags field positions
// ---------------------------------------------------------------
`define ERR_WRITE_MISUSE_BIT 7
`define ERR_OVERFLOW_BIT 4
`define ERR_COLLISION_BIT 3
`define ERR_CHECKSUM_BIT 2
`define ERR_PARITY_BIT 1
`define ERR_PROTOCOL_BIT 0
`define ERR_RESERVED_HI 6
`define ERR_RESERVED_LO 5

// ---------------------------------------------------------------
// general_status field positions
// ---------------------------------------------------------------
`define STAT_FREQ_OK_BIT 7
`define STAT_CRC_ZERO_BIT 6
`define STAT_CRC_DONE_BIT 5
`define STAT_IRQ_BIT 4
`define STAT_TIMER_BIT 3
`define STAT_FIELD_BIT 2
`define STAT_HIGH_ALERT_BIT 1
`define STAT_LOW_ALERT_BIT 0

// ---------------------------------------------------------------
// control register fields, reset values, sizes
// ---------------------------------------------------------------
`define CTRL_FLUSH_BIT 0
`define ERROR_FLAGS_RESET 8'h00
`define GENERAL_STATUS_RESET 8'h00
`define FIFO_CAPACITY 64
`define THRESHOLD_WIDTH 6
`define COMM_IRQ_WIDTH 7
`define MISC_IRQ_WIDTH 5
`define PIN_COUNT 2
`define PIN_FIELD 0
`define PIN_FREQ 1
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// *** status_flags_pkg.sv ***
`default_nettype none

package status_flags_pkg;
   // ---------------------------------------------------------------
   // receive bit rate selected by the receive mode register
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      RATE_106,
      RATE_212,
      RATE_424,
      RATE_848
   } rate_e;

   typedef logic [7:0] flags_t;
endpackage : status_flags_pkg

`default_nettype wire

// *** error_and_status_flags.sv ***
// Notes on behaviour
// - host fifo write in forbidden window flags misuse
// - any write into full fifo flags overflow
// - collision flag, cleared at rx start, 1 off 106
// - checksum fail with checking enabled sets flag
// - parity fail sets flag, only at 106
// - bad start of frame at 106 sets protocol
// - anticollision with initiator bit sets protocol
// - short miller pulse spacing sets protocol
// - error register read only, per command, resets 0
// - frequency ok mirrors synchronised carrier detector
// - checksum zero status, low while calculating
// - checksum done set when calc command finishes
// - irq status is any enabled request
// - timer active while counter will decrement
// - gated mode ignores the external gate
// - field present is live, never latched
// - high alert when free space within threshold
// - low alert when stored count within threshold
// - error interrupt request whenever any error set
// - flush resets pointers and clears overflow
// - stored count follows fifo writes and reads
//
// Added by the designer: register access over AXI4-Lite.
`include "status_flags_defines.svh"
`default_nettype none

module error_and_status_flags #(
   parameter int ADDR_W = 8,
   parameter int FIFO_DEPTH = `FIFO_CAPACITY,
   parameter int CW = $clog2(FIFO_DEPTH + 1)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // fifo traffic as one-cycle pulses, and the alert threshold
   input wire logic fifo_host_write,
   input wire logic fifo_internal_write,
   input wire logic fifo_read,
   input wire logic [`THRESHOLD_WIDTH-1:0] fifo_threshold,
   // command and receiver context
   input wire logic command_start,
   input wire logic auto_anticollision_command,
   input wire logic auto_anticollision_start,
   input wire logic initiator_mode,
   input wire logic tx_rx_gap_active,
   input wire logic rx_startup,
   input wire status_flags_pkg::rate_e rx_rate,
   input wire logic rx_checksum_enable,
   // receiver error events, one-cycle pulses
   input wire logic rx_collision_event,
   input wire logic rx_checksum_fail,
   input wire logic rx_parity_fail,
   input wire logic rx_sof_bad,
   input wire logic miller_short_pulse,
   // checksum coprocessor
   input wire logic crc_busy,
   input wire logic crc_result_zero,
   input wire logic crc_start,
   input wire logic crc_done,
   input wire logic checksum_calc_command,
   // interrupt sources and enables
   input wire logic [`COMM_IRQ_WIDTH-1:0] comm_request,
   input wire logic [`COMM_IRQ_WIDTH-1:0] comm_enable,
   input wire logic [`MISC_IRQ_WIDTH-1:0] misc_request,
   input wire logic [`MISC_IRQ_WIDTH-1:0] misc_enable,
   // timer unit
   input wire logic timer_enabled,
   input wire logic timer_count_zero,
   input wire logic timer_auto_reload,
   // analog detector pins
   input wire logic field_detect_pin,
   input wire logic carrier_freq_pin,
   // outputs
   output logic [7:0] error_flags,
   output logic [7:0] general_status,
   output logic error_interrupt_request,
   output logic fifo_flush,
   output logic [CW-1:0] fifo_stored_count
);
   import status_flags_pkg::*;

   // ---------------------------------------------------------------
   // addresses
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ERR_ADDR =
      ADDR_W'(`ERROR_FLAGS_INDEX * 4);
   localparam logic [ADDR_W-1:0] STAT_ADDR =
      ADDR_W'(`GENERAL_STATUS_INDEX * 4);
   localparam logic [ADDR_W-1:0] CTRL_ADDR =
      ADDR_W'(`FLAGS_CONTROL_INDEX * 4);
   localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic write_fire;
   logic flush_cmd;
   logic fifo_flush_reg;
   logic [CW-1:0] count_reg;
   logic fifo_full;
   logic any_write;
   logic [7:0] error_reg;
   logic [7:0] error_next;
   logic err_irq_reg;
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic crc_done_reg;
   logic [`PIN_COUNT-1:0] pin_raw;
   logic [`PIN_COUNT-1:0] pin_level;
   logic rate_is_106;
   logic [CW-1:0] free_space;

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   // address and data are held until both are in, then one write
   assign write_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
   assign flush_cmd = write_fire &&
      (aw_addr_reg[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]) &&
      w_strb_reg[0] && w_data_reg[`CTRL_FLUSH_BIT];

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         awready_reg <= 1'b1;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         aw_addr_reg <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wready_reg <= 1'b1;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (bvalid_reg && s_axi_bready) begin
         wready_reg <= 1'b1;
      end
   end

   // writes to the read-only registers are accepted and dropped
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `AXI_RESP_OKAY;
      end else if (write_fire) begin
         bvalid_reg <= 1'b1;
         if ((aw_addr_reg[ADDR_W-1:2] == ERR_ADDR[ADDR_W-1:2]) ||
             (aw_addr_reg[ADDR_W-1:2] == STAT_ADDR[ADDR_W-1:2]) ||
             (aw_addr_reg[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2])) begin
            bresp_reg <= `AXI_RESP_OKAY;
         end else begin
            bresp_reg <= `AXI_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `AXI_RESP_OKAY;
         rdata_reg <= '0;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= `AXI_RESP_OKAY;
         rdata_reg <= '0;
         if (s_axi_araddr[ADDR_W-1:2] == ERR_ADDR[ADDR_W-1:2]) begin
            rdata_reg[7:0] <= error_reg;
         end else if (s_axi_araddr[ADDR_W-1:2] ==
                      STAT_ADDR[ADDR_W-1:2]) begin
            rdata_reg[7:0] <= status_reg;
         end else if (s_axi_araddr[ADDR_W-1:2] !=
                      CTRL_ADDR[ADDR_W-1:2]) begin
            rresp_reg <= `AXI_RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // detector pin synchronisers
   // ---------------------------------------------------------------
   assign pin_raw[`PIN_FIELD] = field_detect_pin;
   assign pin_raw[`PIN_FREQ] = carrier_freq_pin;

   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin_sync
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic level_reg;
         always_ff @(posedge mclk) begin
            if (!nrst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               level_reg <= 1'b0;
            end else begin
               s1_reg <= pin_raw[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               // a change counts only once two stages agree
               if (s2_reg == s3_reg) begin
                  level_reg <= s3_reg;
               end
            end
         end
         assign pin_level[gi] = level_reg;
      end
   endgenerate

   // ---------------------------------------------------------------
   // stored byte count and flush
   // ---------------------------------------------------------------
   assign any_write = fifo_host_write | fifo_internal_write;
   assign fifo_full = (count_reg == DEPTH_C);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         count_reg <= '0;
      end else if (flush_cmd) begin
         count_reg <= '0;
      end else if (any_write && !fifo_full && !fifo_read) begin
         count_reg <= count_reg + CW'(1);
      end else if (fifo_read && !any_write && count_reg != '0) begin
         count_reg <= count_reg - CW'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         fifo_flush_reg <= 1'b0;
      end else begin
         fifo_flush_reg <= flush_cmd;
      end
   end

   // ---------------------------------------------------------------
   // error flags
   // ---------------------------------------------------------------
   // in every flag a set in the same cycle as its clear wins
   assign rate_is_106 = (rx_rate == RATE_106);

   always_comb begin
      error_next = error_reg;
      if (command_start) begin
         error_next = `ERROR_FLAGS_RESET;
      end
      if (rx_startup) begin
         error_next[`ERR_COLLISION_BIT] = 1'b0;
         error_next[`ERR_CHECKSUM_BIT] = 1'b0;
         error_next[`ERR_PARITY_BIT] = 1'b0;
         error_next[`ERR_PROTOCOL_BIT] = 1'b0;
      end
      if (flush_cmd) begin
         error_next[`ERR_OVERFLOW_BIT] = 1'b0;
      end
      if (fifo_host_write &&
          (auto_anticollision_command || tx_rx_gap_active)) begin
         error_next[`ERR_WRITE_MISUSE_BIT] = 1'b1;
      end
      if (any_write && fifo_full) begin
         error_next[`ERR_OVERFLOW_BIT] = 1'b1;
      end
      if (rx_collision_event || !rate_is_106) begin
         error_next[`ERR_COLLISION_BIT] = 1'b1;
      end
      if (rx_checksum_enable && rx_checksum_fail) begin
         error_next[`ERR_CHECKSUM_BIT] = 1'b1;
      end
      if (rx_parity_fail && rate_is_106) begin
         error_next[`ERR_PARITY_BIT] = 1'b1;
      end
      if ((rx_sof_bad && rate_is_106) ||
          (auto_anticollision_start && initiator_mode) ||
          miller_short_pulse) begin
         error_next[`ERR_PROTOCOL_BIT] = 1'b1;
      end
      error_next[`ERR_RESERVED_HI:`ERR_RESERVED_LO] = 2'b00;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         error_reg <= `ERROR_FLAGS_RESET;
         err_irq_reg <= 1'b0;
      end else begin
         error_reg <= error_next;
         err_irq_reg <= |error_next;
      end
   end

   // ---------------------------------------------------------------
   // general status
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         crc_done_reg <= 1'b0;
      end else if (crc_done && checksum_calc_command) begin
         crc_done_reg <= 1'b1;
      end else if (crc_start) begin
         crc_done_reg <= 1'b0;
      end
   end

   // alerts use the registered count, so they trail it by one cycle
   assign free_space = DEPTH_C - count_reg;

   always_comb begin
      status_next = `GENERAL_STATUS_RESET;
      status_next[`STAT_FREQ_OK_BIT] = pin_level[`PIN_FREQ];
      status_next[`STAT_CRC_ZERO_BIT] =
         crc_result_zero & ~crc_busy;
      status_next[`STAT_CRC_DONE_BIT] = crc_done_reg;
      status_next[`STAT_IRQ_BIT] = |(comm_request & comm_enable) |
         |(misc_request & misc_enable);
      // the gate only pauses ticks, so it plays no part here
      status_next[`STAT_TIMER_BIT] = timer_enabled &
         (~timer_count_zero | timer_auto_reload);
      status_next[`STAT_FIELD_BIT] = pin_level[`PIN_FIELD];
      status_next[`STAT_HIGH_ALERT_BIT] =
         (free_space <= CW'(fifo_threshold));
      status_next[`STAT_LOW_ALERT_BIT] =
         (count_reg <= CW'(fifo_threshold));
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         status_reg <= `GENERAL_STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign error_flags = error_reg;
   assign general_status = status_reg;
   assign error_interrupt_request = err_irq_reg;
   assign fifo_flush = fifo_flush_reg;
   assign fifo_stored_count = count_reg;

endmodule : error_and_status_flags

`default_nettype wire

// *** error_and_status_flags_properties.sv ***
`include "status_flags_defines.svh"
`default_nettype none

module flags_checker #(
   parameter int FIFO_DEPTH = `FIFO_CAPACITY,
   parameter int CW = $clog2(FIFO_DEPTH + 1)
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // fifo and receiver inputs
   input wire logic fifo_host_write,
   input wire logic fifo_internal_write,
   input wire logic fifo_read,
   input wire logic [`THRESHOLD_WIDTH-1:0] fifo_threshold,
   input wire logic rx_startup,
   input wire status_flags_pkg::rate_e rx_rate,
   input wire logic rx_checksum_enable,
   input wire logic rx_checksum_fail,
   input wire logic rx_parity_fail,
   input wire logic field_detect_pin,
   // watched outputs
   input wire logic [7:0] error_flags,
   input wire logic [7:0] general_status,
   input wire logic error_interrupt_request,
   input wire logic fifo_flush,
   input wire logic [CW-1:0] fifo_stored_count
);
   import status_flags_pkg::*;

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence full_write;
      (fifo_host_write || fifo_internal_write) && !fifo_read &&
         fifo_stored_count == CW'(FIFO_DEPTH);
   endsequence

   // pin passes a synchroniser, so only a settled level is judged
   sequence field_steady;
      $stable(field_detect_pin) [*7];
   endsequence

   irq_mirror_a: assert property (
      error_interrupt_request == |error_flags)
      else $error("error request differs from flags");
   reserved_zero_a: assert property (error_flags[6:5] == 2'h0)
      else $error("reserved error bits not zero");
   parity_set_a: assert property (
      rx_parity_fail && rx_rate == RATE_106 |=> error_flags[1])
      else $error("parity failure not flagged");
   checksum_set_a: assert property (
      rx_checksum_fail && rx_checksum_enable |=> error_flags[2])
      else $error("checksum failure not flagged");
   overflow_set_a: assert property (
      full_write |=> error_flags[4] && $stable(fifo_stored_count))
      else $error("write into full fifo mishandled");
   collision_fast_a: assert property (
      rx_rate != RATE_106 |=> error_flags[3])
      else $error("collision flag low at high rate");
   startup_clear_a: assert property (
      rx_startup && !rx_checksum_fail && !rx_parity_fail
         |=> error_flags[2:1] == 2'h0)
      else $error("receiver start left errors set");
   flush_clear_a: assert property (
      fifo_flush |-> !(|fifo_stored_count) && !error_flags[4])
      else $error("flush did not clear count or overflow");
   fifo_alerts_a: assert property ($past(nrst) |->
      general_status[1:0] == {
         FIFO_DEPTH - $past(fifo_stored_count) <= $past(fifo_threshold),
         $past(fifo_stored_count) <= $past(fifo_threshold)})
      else $error("fifo alert bits wrong");
   field_live_a: assert property (
      field_steady |-> general_status[2] == field_detect_pin)
      else $error("field status does not follow pin");
endmodule : flags_checker

bind error_and_status_flags flags_checker #(
   .FIFO_DEPTH(FIFO_DEPTH),
   .CW(CW)
) u_flags_checker (
   .mclk(mclk), .nrst(nrst), .fifo_host_write(fifo_host_write),
   .fifo_internal_write(fifo_internal_write), .fifo_read(fifo_read),
   .fifo_threshold(fifo_threshold), .rx_startup(rx_startup),
   .rx_rate(rx_rate), .rx_checksum_enable(rx_checksum_enable),
   .rx_checksum_fail(rx_checksum_fail), .rx_parity_fail(rx_parity_fail),
   .field_detect_pin(field_detect_pin), .error_flags(error_flags),
   .general_status(general_status),
   .error_interrupt_request(error_interrupt_request),
   .fifo_flush(fifo_flush), .fifo_stored_count(fifo_stored_count)
);

`default_nettype wire

// *** error_and_status_flags_test.sv ***
`default_nettype none

module error_and_status_flags_test;
   timeunit 1ns;
   timeprecision 1ps;
   import status_flags_pkg::*;

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [12:0] E_PAR = 13'h0001, E_SOF = 13'h0002;
   localparam logic [12:0] E_COL = 13'h0004, E_CKF = 13'h0008;
   localparam logic [12:0] E_MIL = 13'h0010, E_RXS = 13'h0020;
   localparam logic [12:0] E_CMD = 13'h0040, E_ACS = 13'h0080;
   localparam logic [12:0] E_HW = 13'h0100, E_IW = 13'h0200;
   localparam logic [12:0] E_RD = 13'h0400, E_CS = 13'h0800;
   localparam logic [12:0] E_CD = 13'h1000;
   logic mclk = 1'h0, nrst = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // event pulses share one vector so one task can drive any mix
   logic [12:0] ev = 13'h0;
   logic [5:0] fifo_threshold = 6'h04;
   rate_e rx_rate = RATE_106;
   logic rx_checksum_enable = 1'h0, initiator_mode = 1'h0;
   logic auto_anticollision_command = 1'h0, tx_rx_gap_active = 1'h0;
   logic crc_busy = 1'h0, crc_result_zero = 1'h0;
   logic checksum_calc_command = 1'h0, timer_enabled = 1'h0;
   logic timer_count_zero = 1'h0, timer_auto_reload = 1'h0;
   logic field_detect_pin = 1'h0, carrier_freq_pin = 1'h0;
   logic [6:0] comm_request = 7'h0, comm_enable = 7'h0;
   logic [4:0] misc_request = 5'h0, misc_enable = 5'h0;
   logic [7:0] error_flags, general_status;
   logic error_interrupt_request, fifo_flush;
   logic [6:0] fifo_stored_count;
   int bad_count = 0, n_checks = 0, cnt = 0, flush_seen = 0;

   always #12.5 mclk = ~mclk;

   // the flush strobe stands one cycle, inside the write task
   always @(posedge mclk) begin
      if (fifo_flush === 1'h1) flush_seen++;
   end

   error_and_status_flags u_dut (
      .mclk(mclk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .fifo_host_write(ev[8]), .fifo_internal_write(ev[9]),
      .fifo_read(ev[10]), .fifo_threshold(fifo_threshold),
      .command_start(ev[6]),
      .auto_anticollision_command(auto_anticollision_command),
      .auto_anticollision_start(ev[7]), .initiator_mode(initiator_mode),
      .tx_rx_gap_active(tx_rx_gap_active), .rx_startup(ev[5]),
      .rx_rate(rx_rate), .rx_checksum_enable(rx_checksum_enable),
      .rx_collision_event(ev[2]), .rx_checksum_fail(ev[3]),
      .rx_parity_fail(ev[0]), .rx_sof_bad(ev[1]),
      .miller_short_pulse(ev[4]), .crc_busy(crc_busy),
      .crc_result_zero(crc_result_zero), .crc_start(ev[11]),
      .crc_done(ev[12]), .checksum_calc_command(checksum_calc_command),
      .comm_request(comm_request), .comm_enable(comm_enable),
      .misc_request(misc_request), .misc_enable(misc_enable),
      .timer_enabled(timer_enabled), .timer_count_zero(timer_count_zero),
      .timer_auto_reload(timer_auto_reload),
      .field_detect_pin(field_detect_pin),
      .carrier_freq_pin(carrier_freq_pin), .error_flags(error_flags),
      .general_status(general_status),
      .error_interrupt_request(error_interrupt_request),
      .fifo_flush(fifo_flush), .fifo_stored_count(fifo_stored_count)
   );

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task complete_run;
      if (bad_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, r);
      @(posedge mclk);
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, r);
      @(posedge mclk);
   endtask : rd

   // three edges: event and flag land together, alerts follow the count, then one spare
   task pulse(input logic [12:0] m, input logic [7:0] f);
      ev <= m;
      @(posedge mclk);
      ev <= 13'h0;
      repeat (2) @(posedge mclk);
      chk(error_flags, f);
      chk(error_interrupt_request, |f);
   endtask : pulse

   task stat(input logic [7:0] s);
      repeat (8) @(posedge mclk);
      rd(8'h1c, {24'h0, s}, 2'h0);
   endtask : stat

   initial begin
      #200000;
      bad_count++;
      complete_run;
   end

   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'h1;
      @(posedge mclk);
      chk(error_flags, 8'h00);
      rd(8'h1c, 32'h1, 2'h0);
      wr(8'h18, 32'hff, 2'h0);
      rd(8'h18, 32'h0, 2'h0);
      wr(8'h24, 32'h1, 2'h2);
      rd(8'h24, 32'h0, 2'h2);
      pulse(E_PAR, 8'h02);
      rd(8'h18, 32'h2, 2'h0);
      for (int i = 1; i < 3; i++) begin
         rx_rate <= rate_e'(i);
         pulse(E_RXS | E_PAR | E_SOF, 8'h08);
      end
      rx_rate <= RATE_106;
      pulse(E_RXS, 8'h00);
      pulse(E_COL, 8'h08);
      pulse(E_SOF, 8'h09);
      pulse(E_CKF, 8'h09);
      rx_checksum_enable <= 1'h1;
      pulse(E_CKF, 8'h0d);
      pulse(E_RXS, 8'h00);
      pulse(E_MIL, 8'h01);
      pulse(E_CMD, 8'h00);
      pulse(E_ACS, 8'h00);
      initiator_mode <= 1'h1;
      pulse(E_ACS, 8'h01);
      auto_anticollision_command <= 1'h1;
      pulse(E_HW, 8'h81);
      auto_anticollision_command <= 1'h0;
      tx_rx_gap_active <= 1'h1;
      pulse(E_CMD, 8'h00);
      pulse(E_HW, 8'h80);
      tx_rx_gap_active <= 1'h0;
      pulse(E_CMD, 8'h00);
      cnt = 2;
      while (cnt < 64) begin
         pulse(E_HW, 8'h00);
         cnt++;
         chk(fifo_stored_count, cnt);
         chk(general_status[1:0], {64 - cnt <= 4, cnt <= 4});
      end
      pulse(E_IW, 8'h10);
      pulse(E_HW, 8'h10);
      chk(fifo_stored_count, 7'h40);
      pulse(E_RD, 8'h10);
      chk(fifo_stored_count, 7'h3f);
      wr(8'h40, 32'h1, 2'h0);
      chk(flush_seen, 1);
      chk(fifo_stored_count, 7'h00);
      chk(error_flags, 8'h00);
      crc_result_zero <= 1'h1;
      crc_busy <= 1'h1;
      stat(8'h01);
      crc_busy <= 1'h0;
      stat(8'h41);
      checksum_calc_command <= 1'h1;
      pulse(E_CS, 8'h00);
      pulse(E_CD, 8'h00);
      stat(8'h61);
      comm_request <= 7'h01;
      misc_request <= 5'h02;
      stat(8'h61);
      misc_enable <= 5'h02;
      stat(8'h71);
      misc_enable <= 5'h00;
      comm_enable <= 7'h01;
      stat(8'h71);
      comm_request <= 7'h00;
      stat(8'h61);
      timer_enabled <= 1'h1;
      stat(8'h69);
      timer_count_zero <= 1'h1;
      stat(8'h61);
      timer_auto_reload <= 1'h1;
      stat(8'h69);
      field_detect_pin <= 1'h1;
      carrier_freq_pin <= 1'h1;
      stat(8'hed);
      field_detect_pin <= 1'h0;
      stat(8'he9);
      pulse(E_CS, 8'h00);
      stat(8'hc9);
      complete_run;
   end
endmodule : error_and_status_flags_test

`default_nettype wire
